// ===== rtl/hbridge_current_chop_control.sv
// Current chopping, decay control and protection of one H-bridge
//
// The implementer's own choices: the placing of the registers and register access over AXI4-Lite.
`timescale 1ns/1ps
module hbridge_current_chop_control
  import hbridge_pkg::*;
#(
  parameter int RETRY_COUNT = hbridge_pkg::RETRY_CYC,
  parameter int BLANK_COUNT = hbridge_pkg::BLANK_CYC
) (
  // Clock and reset
  input  wire logic                    aclk,
  input  wire logic                    aresetn,
  // AXI4-Lite write
  input  wire logic [7:0]              s_axi_awaddr,
  input  wire logic                    s_axi_awvalid,
  output logic                         s_axi_awready,
  input  wire logic [31:0]             s_axi_wdata,
  input  wire logic [3:0]              s_axi_wstrb,
  input  wire logic                    s_axi_wvalid,
  output logic                         s_axi_wready,
  output logic [1:0]                   s_axi_bresp,
  output logic                         s_axi_bvalid,
  input  wire logic                    s_axi_bready,
  // AXI4-Lite read
  input  wire logic [7:0]              s_axi_araddr,
  input  wire logic                    s_axi_arvalid,
  output logic                         s_axi_arready,
  output logic [31:0]                  s_axi_rdata,
  output logic [1:0]                   s_axi_rresp,
  output logic                         s_axi_rvalid,
  input  wire logic                    s_axi_rready,
  // Controller pins and sense comparators
  input  wire hbridge_pkg::ctrl_pins_t pins_in,
  input  wire hbridge_pkg::sense_t     sense_in,
  // Open-drain indications
  input  wire logic                    regulation_active_n_i,
  output logic                         regulation_active_n_o,
  output logic                         regulation_active_n_oe,
  input  wire logic                    fault_n_i,
  output logic                         fault_n_o,
  output logic                         fault_n_oe,
  // Analog control
  output logic [9:0]                   trip_threshold,
  output hbridge_pkg::bridge_t         bridge
);
  import hbridge_pkg::*;

  localparam int SW = $bits(ctrl_pins_t) + $bits(sense_t) + 2;

  // ------------------------------------------------------------
  // Pin synchronisers
  // ------------------------------------------------------------
  ctrl_pins_t      pins;
  sense_t          sense;
  logic            regact_pin;
  logic            fault_pin;

  sync_bits #(.W(SW)) u_sync (
    .aclk    (aclk),
    .aresetn (aresetn),
    .d       ({pins_in, sense_in, regulation_active_n_i, fault_n_i}),
    .q       ({pins, sense, regact_pin, fault_pin})
  );

  // ------------------------------------------------------------
  // Off time setting
  // ------------------------------------------------------------
  logic [7:0]       offr_kohm_q, offr_kohm_d;
  logic             reg_en_q, reg_en_d;
  logic [CNT_W-1:0] toff_q, toff_d;
  logic [CNT_W-1:0] slow_rem_q, slow_rem_d;
  logic [PROD_W-1:0] prod;
  logic [PROD_W-1:0] cyc;
  logic [PROD_W-1:0] split;
  logic [1:0]       decay_mode;

  assign decay_mode = {pins.decay_sel_bit1, pins.decay_sel_bit0};

  always_comb begin
    prod = PROD_W'(offr_kohm_q) * PROD_W'(KTOFF_NS_KOHM);
    cyc  = prod / PROD_W'(CLK_PERIOD_NS);
    if (pins.off_time_set_pin) begin
      toff_d = TOFF_DEF_CYC;
    end else if (cyc < PROD_W'(TOFF_MIN_CYC)) begin
      toff_d = TOFF_MIN_CYC;
    end else if (cyc > PROD_W'(TOFF_MAX_CYC)) begin
      toff_d = TOFF_MAX_CYC;
    end else begin
      toff_d = cyc[CNT_W-1:0];
    end
    // Remaining count at which the fast part hands over to slow
    unique case (decay_mode)
      DECAY_SLOW:  split = PROD_W'(toff_q);
      DECAY_MIX30: split = PROD_W'(toff_q) * PROD_W'(PCT_FULL - PCT_MIX30)
                           / PROD_W'(PCT_FULL);
      DECAY_MIX60: split = PROD_W'(toff_q) * PROD_W'(PCT_FULL - PCT_MIX60)
                           / PROD_W'(PCT_FULL);
      DECAY_FAST:  split = '0;
    endcase
    slow_rem_d = split[CNT_W-1:0];
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      toff_q     <= TOFF_DEF_CYC;
      slow_rem_q <= TOFF_DEF_CYC;
    end else begin
      toff_q     <= toff_d;
      slow_rem_q <= slow_rem_d;
    end
  end

  // ------------------------------------------------------------
  // Protection
  // ------------------------------------------------------------
  logic [CNT_W-1:0]   blank_q, blank_d;
  logic               hot_q, hot_d;
  logic               ovc_event;
  logic               retry_busy;
  logic               fault;
  logic               bridge_on;
  logic               driving;

  assign driving   = bridge.a_hs | bridge.a_ls | bridge.b_hs | bridge.b_ls;
  // Deglitch: level must persist past the blanking count
  assign ovc_event = sense.ovc_above && driving &&
                     (blank_q == CNT_W'(BLANK_COUNT));

  down_timer #(.W(RETRY_W)) u_retry (
    .aclk     (aclk),
    .aresetn  (aresetn),
    .load     (ovc_event),
    .load_val (RETRY_W'(RETRY_COUNT)),
    .rem      (),
    .busy     (retry_busy)
  );

  always_comb begin
    blank_d = '0;
    if (sense.ovc_above && driving && !retry_busy &&
        blank_q != CNT_W'(BLANK_COUNT)) begin
      blank_d = blank_q + CNT_W'(1);
    end
    hot_d = hot_q;
    if (sense.temp_hot) begin
      hot_d = 1'b1;
    end else if (sense.temp_cool) begin
      hot_d = 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      blank_q <= '0;
      hot_q   <= 1'b0;
    end else begin
      blank_q <= blank_d;
      hot_q   <= hot_d;
    end
  end

  // Any active cause keeps the bridge off until all clear
  assign fault     = retry_busy | hot_q | sense.supply_low_lockout;
  assign bridge_on = pins.bridge_enable && !fault && !ovc_event;

  // ------------------------------------------------------------
  // Regulation loop
  // ------------------------------------------------------------
  reg_state_t       state_q, state_d;
  logic             pwm_a_q, pwm_b_q;
  logic             pwm_edge;
  logic             fast_hiz_q, fast_hiz_d;
  logic             off_load;
  logic [CNT_W-1:0] off_rem;

  assign pwm_edge = (pins.pwm_in_a != pwm_a_q) || (pins.pwm_in_b != pwm_b_q);

  // PWM edges re-arm the timer while the loop holds control
  assign off_load = (state_q == ST_DRIVE) ?
                    (state_d != ST_DRIVE) :
                    (pwm_edge && state_d != ST_DRIVE);

  down_timer #(.W(CNT_W)) u_off (
    .aclk     (aclk),
    .aresetn  (aresetn),
    .load     (off_load),
    .load_val (toff_q),
    .rem      (off_rem),
    .busy     ()
  );

  always_comb begin
    state_d    = state_q;
    fast_hiz_d = 1'b0;
    unique case (state_q)
      ST_DRIVE: begin
        if (bridge_on && reg_en_q && sense.trip_above) begin
          if (decay_mode == DECAY_SLOW) begin
            state_d = ST_SLOW;
          end else begin
            state_d = ST_FAST;
          end
        end
      end
      ST_FAST: begin
        fast_hiz_d = fast_hiz_q | sense.near_zero;
        if (!bridge_on) begin
          state_d = ST_DRIVE;
        end else if (!pwm_edge && off_rem <= slow_rem_q) begin
          state_d = (off_rem == '0) ? ST_DRIVE : ST_SLOW;
        end
      end
      ST_SLOW: begin
        if (!bridge_on || (!pwm_edge && off_rem == '0)) begin
          state_d = ST_DRIVE;
        end
      end
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_q    <= ST_DRIVE;
      pwm_a_q    <= 1'b0;
      pwm_b_q    <= 1'b0;
      fast_hiz_q <= 1'b0;
    end else begin
      state_q    <= state_d;
      pwm_a_q    <= pins.pwm_in_a;
      pwm_b_q    <= pins.pwm_in_b;
      fast_hiz_q <= fast_hiz_d;
    end
  end

  // ------------------------------------------------------------
  // Bridge and indication outputs
  // ------------------------------------------------------------
  bridge_t    bridge_d;
  logic       regact_oe_d;
  logic [9:0] trip_d;

  always_comb begin
    bridge_d = '0;
    if (bridge_on) begin
      unique case (state_d)
        ST_DRIVE: begin
          bridge_d.a_hs = pins.pwm_in_a;
          bridge_d.a_ls = !pins.pwm_in_a;
          bridge_d.b_hs = pins.pwm_in_b;
          bridge_d.b_ls = !pins.pwm_in_b;
        end
        ST_FAST: begin
          if (pins.pwm_in_a == pins.pwm_in_b) begin
            bridge_d.a_ls = 1'b1;
            bridge_d.b_ls = 1'b1;
          end else if (!fast_hiz_d) begin
            bridge_d.a_hs = pins.pwm_in_b;
            bridge_d.a_ls = pins.pwm_in_a;
            bridge_d.b_hs = pins.pwm_in_a;
            bridge_d.b_ls = pins.pwm_in_b;
          end
        end
        ST_SLOW: begin
          bridge_d.a_ls = 1'b1;
          bridge_d.b_ls = 1'b1;
        end
      endcase
    end
    // Only the loop's own off phase pulls the pin, never PWM brake
    regact_oe_d = bridge_on && (state_d != ST_DRIVE);
    trip_d      = TRIP_PERMIL[pins.current_level_sel];
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bridge                 <= '0;
      regulation_active_n_oe <= 1'b0;
      fault_n_oe             <= 1'b0;
      trip_threshold         <= '0;
    end else begin
      bridge                 <= bridge_d;
      regulation_active_n_oe <= regact_oe_d;
      fault_n_oe             <= fault | ovc_event;
      trip_threshold         <= trip_d;
    end
  end

  assign regulation_active_n_o = 1'b0;
  assign fault_n_o             = 1'b0;

  // ------------------------------------------------------------
  // AXI4-Lite slave
  // ------------------------------------------------------------
  logic        aw_q, aw_d, w_q, w_d;
  logic [7:0]  awaddr_q, awaddr_d;
  logic [31:0] wdata_q, wdata_d;
  logic [3:0]  wstrb_q, wstrb_d;
  logic        bvalid_d, rvalid_d;
  logic [1:0]  bresp_d, rresp_d;
  logic [31:0] rdata_d;
  logic [2:0]  events_q, events_d;
  logic [2:0]  ev_set;
  logic        hot_prev_q, uv_prev_q;
  logic        do_wr;
  status_t     status;

  assign s_axi_awready = !aw_q && !s_axi_bvalid;
  assign s_axi_wready  = !w_q && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;
  assign do_wr         = aw_q && w_q && !s_axi_bvalid;

  assign ev_set = {sense.supply_low_lockout && !uv_prev_q,
                   hot_q && !hot_prev_q, ovc_event};

  assign status = '{events: events_q, fault_pin: !fault_pin,
                    regact_pin: !regact_pin, fast_hiz: fast_hiz_q,
                    supply_low: sense.supply_low_lockout, thermal: hot_q,
                    ovc_retry: retry_busy, fault: fault,
                    regulating: state_q != ST_DRIVE};

  always_comb begin
    aw_d        = aw_q;
    w_d         = w_q;
    awaddr_d    = awaddr_q;
    wdata_d     = wdata_q;
    wstrb_d     = wstrb_q;
    bvalid_d    = s_axi_bvalid && !s_axi_bready;
    bresp_d     = s_axi_bresp;
    rvalid_d    = s_axi_rvalid && !s_axi_rready;
    rresp_d     = s_axi_rresp;
    rdata_d     = s_axi_rdata;
    reg_en_d    = reg_en_q;
    offr_kohm_d = offr_kohm_q;
    events_d    = events_q;
    if (s_axi_awvalid && s_axi_awready) begin
      aw_d     = 1'b1;
      awaddr_d = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      w_d     = 1'b1;
      wdata_d = s_axi_wdata;
      wstrb_d = s_axi_wstrb;
    end
    if (do_wr) begin
      aw_d     = 1'b0;
      w_d      = 1'b0;
      bvalid_d = 1'b1;
      bresp_d  = RESP_OKAY;
      unique case ({awaddr_q[7:2], 2'b00})
        ADDR_CTRL:   if (wstrb_q[0]) reg_en_d = wdata_q[0];
        ADDR_OFFR:   if (wstrb_q[0]) offr_kohm_d = wdata_q[7:0];
        ADDR_EVENTS: if (wstrb_q[0]) events_d = events_q & ~wdata_q[2:0];
        ADDR_STATUS, ADDR_LEVEL: ;
        default:     bresp_d = RESP_SLVERR;
      endcase
    end
    // New events win over a simultaneous clear
    events_d = events_d | ev_set;
    if (s_axi_arvalid && s_axi_arready) begin
      rvalid_d = 1'b1;
      rresp_d  = RESP_OKAY;
      unique case ({s_axi_araddr[7:2], 2'b00})
        ADDR_CTRL:   rdata_d = {31'h0, reg_en_q};
        ADDR_OFFR:   rdata_d = {24'h0, offr_kohm_q};
        ADDR_STATUS: rdata_d = {21'h0, status};
        ADDR_LEVEL:  rdata_d = {10'h0, toff_q, trip_threshold};
        ADDR_EVENTS: rdata_d = {29'h0, events_q};
        default: begin
          rdata_d = '0;
          rresp_d = RESP_SLVERR;
        end
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_q         <= 1'b0;
      w_q          <= 1'b0;
      awaddr_q     <= '0;
      wdata_q      <= '0;
      wstrb_q      <= '0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
      s_axi_rvalid <= 1'b0;
      s_axi_rresp  <= RESP_OKAY;
      s_axi_rdata  <= '0;
      reg_en_q     <= CTRL_RST;
      offr_kohm_q  <= OFFR_RST;
      events_q     <= '0;
      hot_prev_q   <= 1'b0;
      uv_prev_q    <= 1'b0;
    end else begin
      aw_q         <= aw_d;
      w_q          <= w_d;
      awaddr_q     <= awaddr_d;
      wdata_q      <= wdata_d;
      wstrb_q      <= wstrb_d;
      s_axi_bvalid <= bvalid_d;
      s_axi_bresp  <= bresp_d;
      s_axi_rvalid <= rvalid_d;
      s_axi_rresp  <= rresp_d;
      s_axi_rdata  <= rdata_d;
      reg_en_q     <= reg_en_d;
      offr_kohm_q  <= offr_kohm_d;
      events_q     <= events_d;
      hot_prev_q   <= hot_q;
      uv_prev_q    <= sense.supply_low_lockout;
    end
  end
endmodule // hbridge_current_chop_control

// ===== rtl/hbridge_pkg.sv
// Constants, types and register map of the H-bridge chopping control
package hbridge_pkg;

  // ------------------------------------------------------------
  // Timing
  // ------------------------------------------------------------
  localparam int CLK_PERIOD_NS   = 25;
  localparam int TOFF_DEF_NS     = 20000;
  localparam int TOFF_MIN_NS     = 10000;
  localparam int TOFF_MAX_NS     = 80000;
  localparam int KTOFF_NS_KOHM   = 667;
  localparam int RETRY_NS        = 3000000;
  localparam int BLANK_NS        = 1000;
  localparam int CNT_W           = 12;
  localparam int RETRY_W         = 17;
  localparam int PROD_W          = 20;

  localparam logic [CNT_W-1:0] TOFF_DEF_CYC =
    CNT_W'(TOFF_DEF_NS / CLK_PERIOD_NS);
  localparam logic [CNT_W-1:0] TOFF_MIN_CYC =
    CNT_W'((TOFF_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [CNT_W-1:0] TOFF_MAX_CYC =
    CNT_W'(TOFF_MAX_NS / CLK_PERIOD_NS);
  localparam int RETRY_CYC = RETRY_NS / CLK_PERIOD_NS;
  localparam int BLANK_CYC = (BLANK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ------------------------------------------------------------
  // Decay modes and mixed split
  // ------------------------------------------------------------
  localparam logic [1:0] DECAY_SLOW  = 2'h0;
  localparam logic [1:0] DECAY_MIX30 = 2'h1;
  localparam logic [1:0] DECAY_MIX60 = 2'h2;
  localparam logic [1:0] DECAY_FAST  = 2'h3;
  localparam int         PCT_FULL    = 100;
  localparam int         PCT_MIX30   = 30;
  localparam int         PCT_MIX60   = 60;

  // Trip fraction in tenths of a percent of full scale
  localparam logic [9:0] TRIP_PERMIL [16] = '{
    10'h3e8, 10'h3e0, 10'h3d0, 10'h3b9, 10'h391, 10'h362, 10'h32b,
    10'h2e4, 10'h29d, 10'h24f, 10'h1f8, 10'h199, 10'h133, 10'h0cd,
    10'h066, 10'h000};

  // ------------------------------------------------------------
  // Register map
  // ------------------------------------------------------------
  localparam logic [7:0] ADDR_CTRL   = 8'h00;
  localparam logic [7:0] ADDR_OFFR   = 8'h04;
  localparam logic [7:0] ADDR_STATUS = 8'h08;
  localparam logic [7:0] ADDR_LEVEL  = 8'h0c;
  localparam logic [7:0] ADDR_EVENTS = 8'h10;
  localparam logic [7:0] OFFR_RST    = 8'h1e;
  localparam logic       CTRL_RST    = 1'h1;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ------------------------------------------------------------
  // Carriers
  // ------------------------------------------------------------
  typedef struct packed {
    logic       bridge_enable;
    logic       pwm_in_a;
    logic       pwm_in_b;
    logic [3:0] current_level_sel;
    logic       decay_sel_bit1;
    logic       decay_sel_bit0;
    logic       off_time_set_pin;
  } ctrl_pins_t;

  typedef struct packed {
    logic trip_above;
    logic ovc_above;
    logic near_zero;
    logic temp_hot;
    logic temp_cool;
    logic supply_low_lockout;
  } sense_t;

  typedef struct packed {
    logic a_hs;
    logic a_ls;
    logic b_hs;
    logic b_ls;
  } bridge_t;

  typedef struct packed {
    logic [2:0] events;
    logic       fault_pin;
    logic       regact_pin;
    logic       fast_hiz;
    logic       supply_low;
    logic       thermal;
    logic       ovc_retry;
    logic       fault;
    logic       regulating;
  } status_t;

  typedef enum logic [2:0] {
    ST_DRIVE = 3'b001,
    ST_FAST  = 3'b010,
    ST_SLOW  = 3'b100
  } reg_state_t;

endpackage

// ===== rtl/sync_bits.sv
// Two-stage synchroniser for a bundle of asynchronous pin levels
`timescale 1ns/1ps
module sync_bits #(
  parameter int W = 1
) (
  // Clock and reset
  input  wire logic         aclk,
  input  wire logic         aresetn,
  // Levels
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta_q;

  for (genvar i = 0; i < W; i++) begin : g_bit
    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        meta_q[i] <= 1'b0;
        q[i]      <= 1'b0;
      end else begin
        meta_q[i] <= d[i];
        q[i]      <= meta_q[i];
      end
    end
  end
endmodule // sync_bits

// ===== rtl/down_timer.sv
// Loadable down counter used for off interval and retry time
`timescale 1ns/1ps
module down_timer #(
  parameter int W = 12
) (
  // Clock and reset
  input  wire logic         aclk,
  input  wire logic         aresetn,
  // Control
  input  wire logic         load,
  input  wire logic [W-1:0] load_val,
  // State
  output logic      [W-1:0] rem,
  output logic              busy
);
  logic [W-1:0] rem_d;

  always_comb begin
    rem_d = rem;
    if (load) begin
      rem_d = load_val;
    end else if (rem != '0) begin
      rem_d = rem - W'(1);
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rem <= '0;
    end else begin
      rem <= rem_d;
    end
  end

  assign busy = (rem != '0);
endmodule // down_timer

// ===== tb/motor_ctrl_model.sv
// Motor controller model: drives the logic pins, pulls up open drains
`timescale 1ns/1ps
module motor_ctrl_model (
  // Clock and commands
  input  wire logic                    aclk,
  input  wire hbridge_pkg::ctrl_pins_t cmd,
  // Open-drain drivers of the device
  input  wire logic                    ra_o,
  input  wire logic                    ra_oe,
  input  wire logic                    f_o,
  input  wire logic                    f_oe,
  // Pin levels
  output hbridge_pkg::ctrl_pins_t      pins = '0,
  output logic                         ra_n,
  output logic                         f_n
);
  import hbridge_pkg::*;
  // --------------------
  // Pins and pull-ups
  // --------------------
  // Enable moves only between tests, far below the coast rate limit
  always @(posedge aclk) pins <= cmd;
  assign ra_n = ra_oe ? ra_o : 1'h1;
  assign f_n = f_oe ? f_o : 1'h1;
endmodule // motor_ctrl_model

// ===== tb/hbridge_chop_properties.sv
// Port checks of the H-bridge chopping control
`timescale 1ns/1ps
module hbridge_chop_chk (
  // Clock and reset
  input wire logic                    aclk,
  input wire logic                    aresetn,
  // Watched ports
  input wire hbridge_pkg::ctrl_pins_t pins_in,
  input wire hbridge_pkg::sense_t     sense_in,
  input wire logic                    regulation_active_n_oe,
  input wire logic                    fault_n_oe,
  input wire logic [9:0]              trip_threshold,
  input wire hbridge_pkg::bridge_t    bridge
);
  import hbridge_pkg::*;
  // --------------------
  // Properties
  // --------------------
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  // Three edges: two sync stages plus the output register
  chk_coast_off: assert property (
    !pins_in.bridge_enable [*3] |=> bridge == '0 && !regulation_active_n_oe)
    else $error("no coast");
  chk_no_shoot: assert property (
    !(bridge.a_hs && bridge.a_ls) && !(bridge.b_hs && bridge.b_ls))
    else $error("half bridge shorted");
  chk_trip_full: assert property (
    pins_in.current_level_sel == 4'h0 [*3] |=> trip_threshold == 10'h3e8)
    else $error("full scale wrong");
  chk_trip_zero: assert property (
    pins_in.current_level_sel == 4'hf [*3] |=> trip_threshold == 10'h000)
    else $error("zero level wrong");
  chk_hot_off: assert property (
    sense_in.temp_hot [*4] |=> fault_n_oe && bridge == '0)
    else $error("thermal not off");
  chk_low_off: assert property (
    sense_in.supply_low_lockout [*3] |=> fault_n_oe && bridge == '0)
    else $error("undervoltage not off");
  chk_slow_pair: assert property (
    (!pins_in.decay_sel_bit1 && !pins_in.decay_sel_bit0) [*5]
    ##0 (regulation_active_n_oe && !fault_n_oe) |-> bridge == 4'h5)
    else $error("slow decay wrong");
  chk_brake_quiet: assert property (
    (pins_in.pwm_in_a == pins_in.pwm_in_b) [*3] |=> !regulation_active_n_oe)
    else $error("regulation shown in brake");
endmodule // hbridge_chop_chk

// ===== tb/hbridge_current_chop_control_tb.sv
// Bench of the H-bridge chopping control
`timescale 1ns/1ps
module hbridge_current_chop_control_tb;
  import hbridge_pkg::*;
  logic        aclk = 1'h0;
  logic        aresetn = 1'h0;
  logic [7:0]  awaddr = '0, araddr = '0;
  logic [31:0] wdata = '0, rdata, q;
  logic        awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0;
  logic        arvalid = 1'h0, rready = 1'h0;
  logic        awready, wready, bvalid, arready, rvalid, fseen = 1'h0;
  logic [1:0]  bresp, rresp, r;
  logic [9:0]  trip;
  ctrl_pins_t  cmd = '0, pins;
  sense_t      sense = '0;
  bridge_t     br;
  logic        ra_o, ra_oe, ra_n, f_o, f_oe, f_n;
  int          err_count = 0, checks_done = 0, cyc = 0;
  // Rows: {enable, a, b, expected bridge}; trip per level
  logic [6:0]  pw [5] = '{7'h45, 7'h69, 7'h56, 7'h7a, 7'h00};
  logic [9:0]  tp [16] = '{10'h3e8, 10'h3e0, 10'h3d0, 10'h3b9, 10'h391,
    10'h362, 10'h32b, 10'h2e4, 10'h29d, 10'h24f, 10'h1f8, 10'h199,
    10'h133, 10'h0cd, 10'h066, 10'h000};
  // Kilohms and off cycles; last row has the pin tied high
  int          rk [4] = '{60, 255, 5, 20};
  int          rc [4] = '{1600, 3200, 400, 800};
  hbridge_current_chop_control #(.RETRY_COUNT(200), .BLANK_COUNT(4)) dut (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'h1), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .pins_in(pins), .sense_in(sense),
    .regulation_active_n_i(ra_n), .regulation_active_n_o(ra_o),
    .regulation_active_n_oe(ra_oe), .fault_n_i(f_n), .fault_n_o(f_o),
    .fault_n_oe(f_oe), .trip_threshold(trip), .bridge(br));
  motor_ctrl_model ctl (.aclk(aclk), .cmd(cmd), .ra_o(ra_o), .ra_oe(ra_oe),
    .f_o(f_o), .f_oe(f_oe), .pins(pins), .ra_n(ra_n), .f_n(f_n));
  initial forever #12.5 aclk = ~aclk;
  // Sticky so a one-cycle fault pulse is not missed
  always @(negedge aclk) if (f_n === 1'h0) fseen <= 1'h1;
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 12000) begin
      err_count++;
      results();
    end
  end
  task automatic results();
    if (err_count == 0 && checks_done > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge aclk);
  endtask
  // Called at a rising edge, or at a falling one inside wr: sees the settled pre-edge values
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checks_done++;
    if (g !== e) begin
      err_count++;
      $display("Error %0t: got %h want %h", $time, g, e);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic ta, tw;
    ta = 1'h0;
    tw = 1'h0;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    while (!(ta && tw)) begin
      @(negedge aclk);
      ta = ta || (awvalid && awready);
      tw = tw || (wvalid && wready);
      @(posedge aclk);
      if (ta) awvalid <= 1'h0;
      if (tw) wvalid <= 1'h0;
    end
    do @(negedge aclk); while (bvalid !== 1'h1);
    chk(bresp, RESP_OKAY);
    @(posedge aclk);
    bready <= 1'h0;
  endtask
  task automatic rd(input logic [7:0] a);
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    do @(negedge aclk); while (arready !== 1'h1);
    @(posedge aclk);
    arvalid <= 1'h0;
    do @(negedge aclk); while (rvalid !== 1'h1);
    q = rdata;
    r = rresp;
    @(posedge aclk);
    rready <= 1'h0;
  endtask
  // Trip pulse, then wait for the off phase to start
  task automatic tripr();
    sense.trip_above <= 1'h1;
    tick(1);
    sense.trip_above <= 1'h0;
    do @(negedge aclk); while (ra_oe !== 1'h1);
    @(posedge aclk);
  endtask
  initial begin
    tick(10);
    chk(br, 32'h0);
    aresetn <= 1'h1;
    for (int i = 0; i < 16; i++) begin
      cmd <= {pw[i % 4][6:4], 4'(i), 3'h1};
      tick(7);
      chk(br, pw[i % 4][3:0]);
      chk(trip, tp[i]);
      chk(ra_n, 1'h1);
    end
    for (int i = 0; i < 4; i++) begin
      cmd <= {3'h6, 4'h0, 2'h0, 1'(i == 3)};
      wr(ADDR_OFFR, rk[i]);
      tick(4);
      rd(ADDR_LEVEL);
      chk(q[21:10], rc[i]);
    end
    tick(1);
    rd(8'h40);
    chk(r, RESP_SLVERR);
    tripr();
    tick(770);
    chk(br, 32'h5);
    chk(ra_n, 1'h0);
    tick(40);
    chk(ra_n, 1'h1);
    chk(br, 32'h9);
    tripr();
    tick(400);
    cmd <= {3'h5, 4'h0, 3'h1};
    tick(770);
    chk(ra_n, 1'h0);
    tick(50);
    chk(br, 32'h6);
    for (int m = 1; m < 3; m++) begin
      cmd <= {3'h6, 4'h0, 2'(m), 1'h1};
      tick(7);
      tripr();
      tick(800 * 30 * m / 100 - 40);
      chk(br, 32'h6);
      tick(80);
      chk(br, 32'h5);
      tick(800);
    end
    cmd <= {3'h6, 4'h0, 2'h3, 1'h1};
    tick(7);
    tripr();
    chk(br, 32'h6);
    sense.near_zero <= 1'h1;
    tick(7);
    chk(br, 32'h0);
    chk(ra_n, 1'h0);
    sense.near_zero <= 1'h0;
    cmd <= {3'h6, 4'h0, 3'h1};
    tick(800);
    sense.ovc_above <= 1'h1;
    tick(3);
    sense.ovc_above <= 1'h0;
    tick(7);
    chk(fseen, 1'h0);
    sense.ovc_above <= 1'h1;
    tick(12);
    chk(fseen, 1'h1);
    tick(150);
    chk(br, 32'h0);
    sense.ovc_above <= 1'h0;
    tick(100);
    chk(br, 32'h9);
    rd(ADDR_EVENTS);
    chk(q[0], 1'h1);
    sense.supply_low_lockout <= 1'h1;
    sense.temp_hot <= 1'h1;
    tick(7);
    chk(f_n, 1'h0);
    sense.supply_low_lockout <= 1'h0;
    sense.temp_hot <= 1'h0;
    tick(7);
    chk(f_n, 1'h0);
    chk(br, 32'h0);
    rd(ADDR_STATUS);
    chk(q[4:1], 4'h5);
    sense.temp_cool <= 1'h1;
    tick(7);
    chk(f_n, 1'h1);
    chk(br, 32'h9);
    // Single disable at the very end keeps the enable rate low
    cmd <= {pw[4][6:4], 4'h0, 3'h1};
    tick(7);
    chk(br, pw[4][3:0]);
    chk(ra_n, 1'h1);
    results();
  end
endmodule // hbridge_current_chop_control_tb

bind hbridge_current_chop_control hbridge_chop_chk chk (.aclk, .aresetn,
  .pins_in, .sense_in, .regulation_active_n_oe, .fault_n_oe,
  .trip_threshold, .bridge);
